// *** include/rsmap_pkg.sv ***
// rsmap_pkg: offsets, reset values, carriers and lookup functions of the
// sensor configuration register map.
// assumes: one byte-wide internal register bus, all logic on core_clk.
`default_nettype none
package rsmap_pkg;
  // block ranges, decoded one group of sixteen at a time
  localparam int RSMAP_GROUP = 16;
  localparam logic [7:0] RSMAP_ANA_HI = 8'h2f;
  localparam logic [7:0] RSMAP_SIF_LO = 8'h40;
  localparam logic [7:0] RSMAP_SIF_HI = 8'h7f;
  localparam logic [7:0] RSMAP_COL_LO = 8'h80;
  localparam logic [7:0] RSMAP_COL_HI = 8'hbf;
  localparam int RSMAP_COL_DEPTH = 64;
  localparam logic [7:0] RSMAP_COL_RST = 8'h00;
  // analog block offsets
  localparam logic [7:0] RSMAP_COLOUR1_GAIN = 8'h00;
  localparam logic [7:0] RSMAP_COLOUR2_GAIN = 8'h01;
  localparam logic [7:0] RSMAP_COLOUR3_GAIN = 8'h02;
  localparam logic [7:0] RSMAP_COLOUR4_GAIN = 8'h03;
  localparam logic [7:0] RSMAP_TILE_CONFIG = 8'h05;
  localparam logic [7:0] RSMAP_TILE_ROW1_DEF = 8'h06;
  localparam logic [7:0] RSMAP_TILE_ROW2_DEF = 8'h07;
  localparam logic [7:0] RSMAP_TILE_ROW3_DEF = 8'h08;
  localparam logic [7:0] RSMAP_TILE_ROW4_DEF = 8'h09;
  localparam logic [7:0] RSMAP_NEG_REF_CODE = 8'h0a;
  localparam logic [7:0] RSMAP_POS_REF_CODE = 8'h0b;
  localparam logic [7:0] RSMAP_POWER_CONFIG = 8'h0c;
  localparam logic [7:0] RSMAP_RESET_CONTROL = 8'h0e;
  localparam logic [7:0] RSMAP_DEVICE_IDENT = 8'h0f;
  localparam logic [7:0] RSMAP_EXPOSURE_GAIN_A = 8'h10;
  localparam logic [7:0] RSMAP_OUTPUT_DRIVE_CONTROL = 8'h12;
  localparam logic [7:0] RSMAP_BIAS_GEN_CONTROL = 8'h13;
  localparam logic [7:0] RSMAP_COLUMN_DC_OFFSET = 8'h20;
  localparam logic [7:0] RSMAP_EXPOSURE_GAIN_B = 8'h21;
  localparam logic [7:0] RSMAP_GAIN_MODE_SELECT = 8'h22;
  localparam logic [7:0] RSMAP_GLOBAL_OFFSET = 8'h23;
  // sensor interface block offsets
  localparam logic [7:0] RSMAP_CAPTURE_CONTROL = 8'h40;
  localparam logic [7:0] RSMAP_SUBSAMPLE_CONTROL = 8'h41;
  localparam logic [7:0] RSMAP_SYNC_STROBE_CONTROL = 8'h42;
  localparam logic [7:0] RSMAP_WIN_ROW_PTR_HI = 8'h45;
  localparam logic [7:0] RSMAP_WIN_ROW_PTR_LO = 8'h46;
  localparam logic [7:0] RSMAP_WIN_ROW_DEPTH_HI = 8'h47;
  localparam logic [7:0] RSMAP_WIN_ROW_DEPTH_LO = 8'h48;
  localparam logic [7:0] RSMAP_WIN_COL_PTR_HI = 8'h49;
  localparam logic [7:0] RSMAP_WIN_COL_PTR_LO = 8'h4a;
  localparam logic [7:0] RSMAP_WIN_COL_WIDTH_HI = 8'h4b;
  localparam logic [7:0] RSMAP_WIN_COL_WIDTH_LO = 8'h4c;
  localparam logic [7:0] RSMAP_INTEG_TIME_HI = 8'h4e;
  localparam logic [7:0] RSMAP_INTEG_TIME_LO = 8'h4f;
  localparam logic [7:0] RSMAP_VFRAME_ROWS_HI = 8'h50;
  localparam logic [7:0] RSMAP_VFRAME_ROWS_LO = 8'h51;
  localparam logic [7:0] RSMAP_VFRAME_COLS_HI = 8'h52;
  localparam logic [7:0] RSMAP_VFRAME_COLS_LO = 8'h53;
  localparam logic [7:0] RSMAP_FRAME_START_DELAY = 8'h54;
  localparam logic [7:0] RSMAP_LINE_SYNC_DELAY = 8'h55;
  localparam logic [7:0] RSMAP_SYNC_PULSE_LENGTH = 8'h56;
  localparam logic [7:0] RSMAP_GRAY_READOUT_CONTROL = 8'h57;
  localparam logic [7:0] RSMAP_SIGNAL_SAMPLE_TIME = 8'h5f;
  localparam logic [7:0] RSMAP_RESET_SAMPLE_TIME = 8'h60;
  localparam logic [7:0] RSMAP_PIXEL_SYNC_DELAY = 8'h64;
  localparam logic [7:0] RSMAP_STREAM_SIGNAL_CONTROL = 8'h65;
  localparam logic [7:0] RSMAP_FRAME_RATE_CTRL = 8'h67;

  // carriers
  typedef logic [127:0][7:0] rsmap_bytes_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsmap_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rsmap_rsp_t;
  typedef struct packed {
    logic ana;
    logic sif;
    logic col;
  } rsmap_sel_t;

  // writable, readable storage below the column table
  function automatic logic rsmap_rw(input logic [7:0] a);
    return a inside {[RSMAP_COLOUR1_GAIN:RSMAP_COLOUR4_GAIN],
      [RSMAP_TILE_CONFIG:RSMAP_POWER_CONFIG], RSMAP_RESET_CONTROL,
      RSMAP_EXPOSURE_GAIN_A, RSMAP_OUTPUT_DRIVE_CONTROL, RSMAP_BIAS_GEN_CONTROL,
      [RSMAP_COLUMN_DC_OFFSET:RSMAP_GLOBAL_OFFSET],
      [RSMAP_CAPTURE_CONTROL:RSMAP_SYNC_STROBE_CONTROL],
      [RSMAP_WIN_ROW_PTR_HI:RSMAP_WIN_COL_WIDTH_LO],
      [RSMAP_INTEG_TIME_HI:RSMAP_GRAY_READOUT_CONTROL],
      RSMAP_SIGNAL_SAMPLE_TIME, RSMAP_RESET_SAMPLE_TIME,
      [RSMAP_PIXEL_SYNC_DELAY:RSMAP_STREAM_SIGNAL_CONTROL], RSMAP_FRAME_RATE_CTRL};
  endfunction

  // registers that reach the sensor interface only at frame boundaries
  function automatic logic rsmap_shadowed(input logic [7:0] a);
    return a inside {[RSMAP_COLOUR1_GAIN:RSMAP_COLOUR4_GAIN],
      RSMAP_EXPOSURE_GAIN_A, RSMAP_EXPOSURE_GAIN_B,
      [RSMAP_CAPTURE_CONTROL:RSMAP_SYNC_STROBE_CONTROL],
      [RSMAP_WIN_ROW_PTR_HI:RSMAP_WIN_COL_WIDTH_LO],
      [RSMAP_INTEG_TIME_HI:RSMAP_VFRAME_COLS_LO],
      RSMAP_SIGNAL_SAMPLE_TIME, RSMAP_RESET_SAMPLE_TIME,
      RSMAP_PIXEL_SYNC_DELAY};
  endfunction

  // reset value per location; anything unlisted resets to zero
  function automatic logic [7:0] rsmap_rst_val(input logic [7:0] a);
    unique case (a)
      RSMAP_COLOUR1_GAIN, RSMAP_COLOUR2_GAIN, RSMAP_COLOUR3_GAIN,
      RSMAP_COLOUR4_GAIN: return 8'h0e;
      RSMAP_TILE_CONFIG: return 8'h05;
      RSMAP_TILE_ROW1_DEF: return 8'h44;
      RSMAP_TILE_ROW2_DEF: return 8'hee;
      RSMAP_NEG_REF_CODE: return 8'h76;
      RSMAP_POS_REF_CODE: return 8'h80;
      RSMAP_EXPOSURE_GAIN_A, RSMAP_EXPOSURE_GAIN_B: return 8'h0e;
      RSMAP_OUTPUT_DRIVE_CONTROL: return 8'h03;
      RSMAP_CAPTURE_CONTROL: return 8'h2a;
      RSMAP_SUBSAMPLE_CONTROL: return 8'h10;
      RSMAP_SYNC_STROBE_CONTROL: return 8'h02;
      RSMAP_WIN_ROW_PTR_LO: return 8'h10;
      RSMAP_WIN_ROW_DEPTH_HI: return 8'h03;
      RSMAP_WIN_COL_PTR_LO: return 8'h08;
      RSMAP_WIN_COL_WIDTH_HI: return 8'h04;
      RSMAP_WIN_ROW_DEPTH_LO, RSMAP_WIN_COL_WIDTH_LO: return 8'hff;
      RSMAP_INTEG_TIME_HI: return 8'h04;
      RSMAP_INTEG_TIME_LO: return 8'hff;
      RSMAP_VFRAME_ROWS_HI: return 8'h04;
      RSMAP_VFRAME_ROWS_LO: return 8'h27;
      RSMAP_VFRAME_COLS_HI: return 8'h05;
      RSMAP_VFRAME_COLS_LO: return 8'h13;
      RSMAP_FRAME_START_DELAY: return 8'h4c;
      RSMAP_LINE_SYNC_DELAY: return 8'h02;
      RSMAP_SYNC_PULSE_LENGTH: return 8'h0e;
      RSMAP_GRAY_READOUT_CONTROL: return 8'h04;
      RSMAP_SIGNAL_SAMPLE_TIME, RSMAP_RESET_SAMPLE_TIME: return 8'h0a;
      RSMAP_PIXEL_SYNC_DELAY: return 8'h5c;
      RSMAP_FRAME_RATE_CTRL: return 8'h24;
      default: return 8'h00;
    endcase
  endfunction

  function automatic rsmap_bytes_t rsmap_rst_table();
    rsmap_bytes_t t;
    for (int i = 0; i < 128; i++) begin
      t[i] = rsmap_rst_val(8'(i));
    end
    return t;
  endfunction

  localparam rsmap_bytes_t RSMAP_LIVE_RST = rsmap_rst_table();
endpackage
`default_nettype wire

// *** rtl/rsmap_decode.sv ***
// rsmap_decode: picks the one block that answers an internal bus address.
// assumes: address is a plain byte from same-clock logic.
`default_nettype none
module rsmap_decode (
  // address in
  input wire logic [7:0] addr,
  // block select out
  output rsmap_pkg::rsmap_sel_t sel
);
  import rsmap_pkg::*;

  logic [3:0] group;

  // decode on the group nibble only, sixteen locations a group
  assign group = addr[7:4];
  assign sel.ana = (group <= RSMAP_ANA_HI[7:4]);
  assign sel.sif = (group >= RSMAP_SIF_LO[7:4]) && (group <= RSMAP_SIF_HI[7:4]);
  assign sel.col = (group >= RSMAP_COL_LO[7:4]) && (group <= RSMAP_COL_HI[7:4]);
endmodule
`default_nettype wire

// *** rtl/rsmap_coltab.sv ***
// rsmap_coltab: per-column offset coefficient table, one byte per entry.
// assumes: bus index and lookup index come from logic on core_clk.
`default_nettype none
module rsmap_coltab #(
  parameter int DEPTH = rsmap_pkg::RSMAP_COL_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // bus side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] bus_idx,
  input wire logic [7:0] wr_byte,
  output logic [7:0] rd_byte,
  // column correction side
  input wire logic [$clog2(DEPTH)-1:0] look_idx,
  output logic [7:0] look_byte
);
  import rsmap_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] tab;
    logic [7:0] look;
  } rsmap_col_state_t;

  rsmap_col_state_t st_r;
  rsmap_col_state_t st_nxt;

  // bus write and registered lookup for the column correction
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.tab[bus_idx] = wr_byte;
    end
    st_nxt.look = st_r.tab[look_idx];
  end

  // every entry starts cleared
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{tab: {DEPTH{RSMAP_COL_RST}}, look: RSMAP_COL_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_byte = st_r.tab[bus_idx];
  assign look_byte = st_r.look;
endmodule
`default_nettype wire

// *** rtl/rsmap_top.sv ***
// rsmap_top: configuration register bank of the image sensor, reached over
// the internal register bus that the serial slave drives.
// assumes: serial slave, frame timing and column logic all run on core_clk.
//
// Overview of operation
// - address space is decoded in groups of sixteen, at most one block per group.
// - 00-2F analog, 40-7F sensor interface, 80-BF column offset table.
// - only the selected block drives the internal control bus.
// - every register except ident 0F is bus read/write and visible to internal blocks.
// - shadowed registers reach the sensor interface only at frame boundary.
// - four colour gains at 00-03 reset to 0E, shadowed.
// - tile config 05 resets 05; tile rows 06-09 reset 44, EE, 00, 00.
// - negative reference 0A resets 76, positive reference 0B resets 80.
// - 0F is a read-only identification code; writes leave it alone.
// - exposure gains A at 10 and B at 21 reset 0E, shadowed.
// - power 0C, reset ctrl 0E, 20, 22, 23 reset to 00.
// - capture 40 resets 2A, subsample 41 10, sync strobe 42 02; shadowed.
// - window pointer and size pairs at 45-4C are shadowed, with defaults.
// - integration time pair 4E/4F resets 04/FF, shadowed.
// - virtual frame pairs 50/51 and 52/53 reset 04/27, 05/13, shadowed.
// - output timing 54-57 reset 4C, 02, 0E, 04, not shadowed.
// - sample times 5F, 60 reset 0A; pixel sync delay 64 resets 5C.
// - drive 12 resets 03, bias 13 00, stream 65 00, frame rate 67 24.
// - column offset table 80-BF, one byte per entry, resets to 00.
`default_nettype none
module rsmap_top #(
  // identification byte; value arbitrary
  parameter logic [7:0] DEVICE_IDENT = 8'h3c
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // internal register bus from the serial slave
  input wire rsmap_pkg::rsmap_req_t reg_req,
  output logic [$bits(rsmap_pkg::rsmap_rsp_t)-1:0] reg_rsp,
  output logic [2:0] bus_drv,
  // frame timing
  input wire logic frame_boundary,
  // configuration seen by analog and sensor interface logic
  output logic [1023:0] cfg_bytes,
  // column correction lookup
  input wire logic [5:0] col_look_idx,
  output logic [7:0] col_look_byte
);
  import rsmap_pkg::*;

  typedef struct packed {
    rsmap_bytes_t live;
    rsmap_bytes_t shad;
    rsmap_rsp_t rsp;
    rsmap_sel_t drv;
  } rsmap_state_t;

  localparam rsmap_state_t RSMAP_STATE_RST = '{
    live: RSMAP_LIVE_RST,
    shad: RSMAP_LIVE_RST,
    rsp: '0,
    drv: '0
  };

  rsmap_state_t st_r;
  rsmap_state_t st_nxt;
  rsmap_sel_t sel;
  rsmap_bytes_t cfg;
  logic [7:0] col_rd_byte;
  logic col_wr;
  logic [6:0] idx;

  // block select from the group nibble
  rsmap_decode u_decode (
    .addr(reg_req.addr),
    .sel(sel)
  );

  // column table lives in its own block with its own storage
  assign col_wr = reg_req.wr && sel.col;
  rsmap_coltab #(
    .DEPTH(RSMAP_COL_DEPTH)
  ) u_coltab (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(col_wr),
    .bus_idx(reg_req.addr[5:0]),
    .wr_byte(reg_req.wdata),
    .rd_byte(col_rd_byte),
    .look_idx(col_look_idx),
    .look_byte(col_look_byte)
  );

  assign idx = reg_req.addr[6:0];

  // bus access, shadow transfer and read answer
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.valid = reg_req.rd;
    st_nxt.rsp.data = '0;
    st_nxt.drv = '0;
    // only one block owns the answer; the others stay off the bus
    if (reg_req.rd) begin
      st_nxt.drv = sel;
      if (sel.col) begin
        st_nxt.rsp.data = col_rd_byte;
      end else if (sel.ana && reg_req.addr == RSMAP_DEVICE_IDENT) begin
        st_nxt.rsp.data = DEVICE_IDENT;
      end else if ((sel.ana || sel.sif) && rsmap_rw(reg_req.addr)) begin
        st_nxt.rsp.data = st_r.live[idx];
      end
    end
    // unmapped and ident locations simply drop the write
    if (reg_req.wr && (sel.ana || sel.sif) && rsmap_rw(reg_req.addr)) begin
      st_nxt.live[idx] = reg_req.wdata;
    end
    // whole shadow set moves at once so byte pairs never tear;
    // a write in the boundary cycle itself waits for the next frame
    if (frame_boundary) begin
      for (int i = 0; i < 128; i++) begin
        if (rsmap_shadowed(8'(i))) begin
          st_nxt.shad[i] = st_r.live[i];
        end
      end
    end
  end

  // single state register for the whole bank outside the column table
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= RSMAP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // internal view: shadowed bytes from the frame copy, others live
  for (genvar g = 0; g < 128; g++) begin : g_cfg
    assign cfg[g] = rsmap_shadowed(8'(g)) ? st_r.shad[g] : st_r.live[g];
  end

  assign cfg_bytes = cfg;
  assign reg_rsp = st_r.rsp;
  assign bus_drv = st_r.drv;

  // checks on the bank's own behaviour
  AST_UNMAPPED_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && (reg_req.addr[7:4] == 4'h3 || reg_req.addr >= 8'hc0 ||
      reg_req.addr == 8'h0d || reg_req.addr == 8'h61)
    |=> st_r.rsp.valid && st_r.rsp.data == 8'h00)
    else $error("unmapped location did not read zero");

  AST_GROUP_NO_DRIVER: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && (reg_req.addr[7:4] == 4'h3 || reg_req.addr[7:6] == 2'b11)
    |=> bus_drv == 3'b000)
    else $error("a block drove the bus in an unassigned group");

  AST_ONE_DRIVER: assert property (@(posedge core_clk) disable iff (!resetn)
    $onehot0(bus_drv) && (st_r.rsp.valid || bus_drv == 3'b000))
    else $error("more than one block drove the control bus");

  AST_SIF_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr >= RSMAP_SIF_LO && reg_req.addr <= RSMAP_SIF_HI
    |=> st_r.drv.sif && !st_r.drv.ana && !st_r.drv.col)
    else $error("sensor interface range not decoded to its block");

  AST_COL_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr >= RSMAP_COL_LO && reg_req.addr <= RSMAP_COL_HI
    |=> st_r.drv.col && !st_r.drv.sif)
    else $error("column table range not decoded to its block");

  AST_IDENT_RO: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == RSMAP_DEVICE_IDENT ##1
      reg_req.rd && reg_req.addr == RSMAP_DEVICE_IDENT
    |=> st_r.rsp.data == DEVICE_IDENT)
    else $error("identification code changed by a write");

  AST_WRITE_READBACK: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == RSMAP_TILE_CONFIG ##1
      !reg_req.wr && reg_req.rd && reg_req.addr == RSMAP_TILE_CONFIG
    |=> st_r.rsp.valid && st_r.rsp.data == $past(reg_req.wdata, 2))
    else $error("register read back differs from last write");

  AST_UNSHADOWED_LIVE: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == RSMAP_TILE_ROW1_DEF
    |=> cfg[RSMAP_TILE_ROW1_DEF] == $past(reg_req.wdata))
    else $error("unshadowed register not visible the cycle after write");

  AST_SHADOW_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == RSMAP_COLOUR1_GAIN && !frame_boundary
    ##1 !frame_boundary[*3]
    |-> $stable(cfg[RSMAP_COLOUR1_GAIN]))
    else $error("shadowed gain changed inside a frame");

  AST_PAIR_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    frame_boundary
    |=> cfg[RSMAP_INTEG_TIME_HI] == $past(st_r.live[RSMAP_INTEG_TIME_HI]) &&
        cfg[RSMAP_INTEG_TIME_LO] == $past(st_r.live[RSMAP_INTEG_TIME_LO]) &&
        cfg[RSMAP_WIN_ROW_PTR_HI] == $past(st_r.live[RSMAP_WIN_ROW_PTR_HI]) &&
        cfg[RSMAP_WIN_ROW_PTR_LO] == $past(st_r.live[RSMAP_WIN_ROW_PTR_LO]))
    else $error("shadowed pair not loaded together at frame boundary");

  AST_RESET_DEFAULTS: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(resetn)
    |-> cfg[RSMAP_CAPTURE_CONTROL] == 8'h2a && cfg[RSMAP_COLOUR1_GAIN] == 8'h0e &&
        cfg[RSMAP_WIN_COL_WIDTH_HI] == 8'h04 && cfg[RSMAP_FRAME_RATE_CTRL] == 8'h24)
    else $error("register default wrong after reset");

  AST_COL_READBACK: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == 8'h85 ##1
      !reg_req.wr && reg_req.rd && reg_req.addr == 8'h85
    |=> st_r.rsp.data == $past(reg_req.wdata, 2))
    else $error("column table entry did not read back");

  AST_READ_LATENCY: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd |=> st_r.rsp.valid ##1 ($past(reg_req.rd) == st_r.rsp.valid))
    else $error("read answer not exactly one cycle after request");

  COV_SHADOW_UPDATE: cover property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && reg_req.addr == RSMAP_INTEG_TIME_HI ##[1:20] frame_boundary);

  COV_COL_READ: cover property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && sel.col ##1 st_r.rsp.data != 8'h00);

  COV_IDENT_READ: cover property (@(posedge core_clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr == RSMAP_DEVICE_IDENT);

  COV_WRITE_AT_BOUNDARY: cover property (@(posedge core_clk) disable iff (!resetn)
    reg_req.wr && frame_boundary && rsmap_shadowed(reg_req.addr));
endmodule
`default_nettype wire

// *** tb/rsmap_host.sv ***
// rsmap_host: host side of the internal register bus and the frame pulse.
// assumes: requests launch 2 ns after a rising core_clk edge.
`default_nettype none
module rsmap_host (
  // clock
  input wire logic core_clk,
  // requests and frame pulse
  output rsmap_pkg::rsmap_req_t reg_req,
  output logic frame_boundary,
  // answer {valid, data}
  input wire logic [8:0] reg_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsmap_pkg::*;
  // quiet bus at time zero
  initial begin
    reg_req = '0;
    frame_boundary = 1'b0;
  end
  // released address and data flip, so a stale value never matches
  task automatic release_bus();
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
    frame_boundary = 1'b0;
  endtask
  // one write, with a frame boundary in the same cycle if fb is set
  task automatic write(input logic [7:0] a, input logic [7:0] d, input logic fb);
    @(posedge core_clk) #2;
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    frame_boundary = fb;
    @(posedge core_clk) #2;
    release_bus();
  endtask
  // lone frame boundary pulse
  task automatic boundary();
    @(posedge core_clk) #2;
    frame_boundary = 1'b1;
    @(posedge core_clk) #2;
    release_bus();
  endtask
  // read; the answer stands for the one cycle after the request edge only
  task automatic read(input logic [7:0] a, output logic [8:0] r);
    @(posedge core_clk) #2;
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(posedge core_clk) #2;
    release_bus();
    r = reg_rsp;
  endtask
  // write, then read the same address on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
    @(posedge core_clk) #2;
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(posedge core_clk) #2;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b1;
    @(posedge core_clk) #2;
    release_bus();
    r = reg_rsp;
  endtask
endmodule
`default_nettype wire

// *** tb/test_sensor_config_register_map.sv ***
// test_sensor_config_register_map: self-checking bench of the register bank.
// assumes: rsmap_host drives the register bus, core_clk at 40 MHz.
`default_nettype none
module test_sensor_config_register_map;
  timeunit 1ns;
  timeprecision 1ps;
  import rsmap_pkg::*;
  localparam logic [7:0] IDENT = 8'h5a; // arbitrary identification value
  logic core_clk;
  logic resetn;
  rsmap_req_t reg_req;
  logic frame_boundary;
  logic [8:0] reg_rsp;
  logic [2:0] bus_drv;
  logic [1023:0] cfg_bytes;
  logic [5:0] look_idx;
  logic [7:0] look_byte;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  rsmap_top #(.DEVICE_IDENT(IDENT)) DUT (.core_clk(core_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_rsp(reg_rsp), .bus_drv(bus_drv),
    .frame_boundary(frame_boundary), .cfg_bytes(cfg_bytes),
    .col_look_idx(look_idx), .col_look_byte(look_byte));
  rsmap_host host (.core_clk(core_clk), .reg_req(reg_req),
    .frame_boundary(frame_boundary), .reg_rsp(reg_rsp));

  // expected reset byte per address, zero where unlisted
  function automatic logic [7:0] rstv(input logic [7:0] a);
    case (a)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h21, 8'h56: return 8'h0e;
      8'h05, 8'h52: return 8'h05;
      8'h06: return 8'h44;
      8'h07: return 8'hee;
      8'h0a: return 8'h76;
      8'h0b: return 8'h80;
      8'h12, 8'h47: return 8'h03;
      8'h40: return 8'h2a;
      8'h41, 8'h46: return 8'h10;
      8'h42, 8'h55: return 8'h02;
      8'h48, 8'h4c, 8'h4f: return 8'hff;
      8'h4a: return 8'h08;
      8'h4b, 8'h4e, 8'h50, 8'h57: return 8'h04;
      8'h51: return 8'h27;
      8'h53: return 8'h13;
      8'h54: return 8'h4c;
      8'h5f, 8'h60: return 8'h0a;
      8'h64: return 8'h5c;
      8'h67: return 8'h24;
      default: return 8'h00;
    endcase
  endfunction
  // storage that takes writes
  function automatic logic rw(input logic [7:0] a);
    return a inside {[8'h00:8'h03], [8'h05:8'h0c], 8'h0e, 8'h10, 8'h12, 8'h13,
      [8'h20:8'h23], [8'h40:8'h42], [8'h45:8'h4c], [8'h4e:8'h57], 8'h5f, 8'h60,
      8'h64, 8'h65, 8'h67, [8'h80:8'hbf]};
  endfunction
  // bytes that wait for a frame boundary
  function automatic logic sh(input logic [7:0] a);
    return a inside {[8'h00:8'h03], 8'h10, 8'h21, [8'h40:8'h42], [8'h45:8'h4c],
      [8'h4e:8'h53], 8'h5f, 8'h60, 8'h64};
  endfunction
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction
  // one-hot {ana,sif,col} of the answering block
  function automatic logic [2:0] grp(input logic [7:0] a);
    if (a <= 8'h2f) return 3'b100;
    if (a inside {[8'h40:8'h7f]}) return 3'b010;
    if (a inside {[8'h80:8'hbf]}) return 3'b001;
    return 3'b000;
  endfunction

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // every address over the bus, with the answering block
  task automatic sweep_read(input logic wrote);
    logic [8:0] r;
    logic [7:0] e;
    for (int i = 0; i < 256; i++) begin
      host.read(8'(i), r);
      e = (i == 8'h0f) ? IDENT : (wrote && rw(8'(i))) ? pat(8'(i)) : rstv(8'(i));
      chk(r, {1'b1, e}, "read back");
      chk({6'h00, bus_drv}, {6'h00, grp(8'(i))}, "driving block");
    end
  endtask
  // configuration outputs; loaded means shadows hold the pattern
  task automatic chk_cfg(input logic wrote, input logic loaded);
    logic [7:0] a;
    logic [7:0] e;
    @(posedge core_clk) #2;
    for (int n = 0; n < 128; n++) begin
      a = 8'(n);
      e = (wrote && rw(a) && (loaded || !sh(a))) ? pat(a) : rstv(a);
      chk({1'b0, cfg_bytes[8*n+:8]}, {1'b0, e}, "config byte");
    end
  endtask

  task automatic test_defaults();
    chk_cfg(1'b0, 1'b0);
    sweep_read(1'b0);
    $display("test_defaults done");
  endtask
  // writes to storage land live; shadows move only together at the boundary
  task automatic test_write_shadow();
    for (int i = 0; i < 256; i++) host.write(8'(i), pat(8'(i)), 1'b0);
    chk_cfg(1'b1, 1'b0);
    sweep_read(1'b1);
    host.boundary();
    chk_cfg(1'b1, 1'b1);
    $display("test_write_shadow done");
  endtask
  // a write in the boundary cycle waits for the next boundary
  task automatic test_collision();
    logic [8:0] r;
    host.write(RSMAP_INTEG_TIME_HI, 8'h11, 1'b1);
    chk_cfg(1'b1, 1'b1);
    host.read(RSMAP_INTEG_TIME_HI, r);
    chk(r, 9'h111, "live after collision");
    host.boundary();
    @(posedge core_clk) #2;
    chk({1'b0, cfg_bytes[8*RSMAP_INTEG_TIME_HI+:8]}, 9'h011, "late load");
    $display("test_collision done");
  endtask
  // table lookup side sees what the bus wrote
  task automatic test_coltab();
    for (int i = 0; i < 64; i++) begin
      @(posedge core_clk) #2;
      look_idx = 6'(i);
      @(posedge core_clk) #2;
      chk({1'b0, look_byte}, {1'b0, pat(8'(8'h80 + i))}, "column entry");
    end
    $display("test_coltab done");
  endtask
  // back-to-back write and read: ident stays, plain and table bytes land at once
  task automatic test_back_to_back();
    logic [8:0] r;
    host.write_read(RSMAP_DEVICE_IDENT, 8'hc3, r);
    chk(r, {1'b1, IDENT}, "ident after write");
    host.write_read(RSMAP_TILE_CONFIG, 8'h3b, r);
    chk(r, 9'h13b, "tile config readback");
    host.write_read(8'h85, 8'h6e, r);
    chk(r, 9'h16e, "column readback");
    $display("test_back_to_back done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // 25 ns clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard, about three and a half times the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      tally_and_finish();
    end
  end
  // main sequence, ending with a mid-run reset that must restore defaults
  initial begin
    resetn = 1'b0;
    look_idx = 6'h00;
    repeat (2) @(posedge core_clk);
    #2 resetn = 1'b1;
    test_defaults();
    test_write_shadow();
    test_collision();
    test_coltab();
    test_back_to_back();
    @(posedge core_clk) #2 resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #2 resetn = 1'b1;
    test_defaults();
    tally_and_finish();
  end
endmodule
`default_nettype wire
